/* File: hdl/isb_flag_cell.sv */
// Purpose: Bank of sticky event bits.
// Assumes: Set and clear come from logic on the same clock.
// Notes: A set in the clearing cycle is kept.
`default_nettype none

module isb_flag_cell #(
  parameter int W = 4
) (
  // Clock and reset.
  input  wire logic         clk_sys_in,
  input  wire logic         srst_in,
  // Events and clear.
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  // Held bits.
  output logic      [W-1:0] q_out
);

  logic [W-1:0] q_reg;   // Held bits.
  logic [W-1:0] q_next;  // Next held bits.

  // Set wins over clear.
  assign q_next = set_in | (q_reg & ~clr_in);
  assign q_out  = q_reg;

  // State update.
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
      q_reg <= '0;
    else
      q_reg <= q_next;
  end

endmodule

`default_nettype wire

/* File: hdl/isb_top.sv */
// Purpose: Inspection status bit map served to the host links and to
//          software over AXI4-Lite.
// Assumes: Core inputs are on clk_sys_in; link read port is same clock.
// Notes: Remote bit labels 10-17 are octal, equal to binary 8-15.
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
`include "isb_defs.svh"

module isb_top #(
  parameter int PULSE_W = 16
) (
  // Clock and reset.
  input  wire logic               clk_sys_in,
  input  wire logic               srst_in,
  // Inspection core results, gages 21 to 32.
  input  wire logic [11:0]        gage_warn_in,
  input  wire logic [11:0]        gage_fault_in,
  input  wire logic               tool_fail_in,
  input  wire logic               result_post_in,
  input  wire logic               result_part_in,
  // Core mode and configuration events.
  input  wire logic               setup_mode_in,
  input  wire logic               download_active_in,
  input  wire logic               cfg_block_done_in,
  input  wire logic               cfg_block_ok_in,
  input  wire logic               trig_missed_in,
  input  wire logic               trig_accept_in,
  // Current host.
  input  wire logic               master_valid_in,
  input  wire isb_pkg::isb_link_e master_link_in,
  // Link read port.
  input  wire logic               link_rd_in,
  input  wire isb_pkg::isb_link_e link_sel_in,
  input  wire logic [7:0]         link_addr_in,
  output logic [15:0]             link_data_out,
  output logic                    link_valid_out,
  output logic                    link_hit_out,
  // Interrupt.
  output logic                    irq_out,
  // AXI4-Lite write channels.
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);

  // Status state.
  logic [23:0]        flags_reg;     // Gage flags, warn even, fault odd.
  logic [23:0]        flags_ilv;     // Interleaved gage inputs.
  logic               cfg_err_reg;   // Configuration error.
  logic               busy_reg;      // Module busy.
  logic               nak_reg;       // Missed first trigger.
  logic               part_reg;      // Posted part.
  logic               valid_reg;     // Results valid.
  logic               valid_next;    // Next results valid.
  logic               mfault_reg;    // Master fault.
  logic               setup_d_reg;   // Setup mode one cycle ago.
  logic               setup_rise;    // Setup mode entered.
  logic [PULSE_W-1:0] pulse_cnt_reg; // Cycles left of valid pulse.
  logic               pulse_expire;  // Valid pulse ends now.
  logic [PULSE_W-1:0] pulse_len_reg; // Valid pulse length, 0 holds.
  logic [3:0]         mask_reg;      // Interrupt mask.
  logic [3:0]         irq_stat;      // Sticky interrupt bits.
  logic [3:0]         irq_set;       // Interrupt events.
  logic [3:0]         irq_clr;       // Interrupt clear by read.

  // Assembled words.
  logic [15:0] w22;        // Word 22, upper byte ours.
  logic [15:0] w23;        // Word 23.
  logic [15:0] w24;        // Word 24 without mastership.
  logic [15:0] w24_link;   // Word 24 as the reading link sees it.
  logic        link_mast;  // Reading link is the host.

  // Interleave warn and fault per gage.
  for (genvar g = 0; g < 12; g++)
  begin : g_ilv
    assign flags_ilv[2*g]   = gage_warn_in[g];
    assign flags_ilv[2*g+1] = gage_fault_in[g];
  end

  // Word assembly; unused bits 0 and 7 are constant zero.
  assign w22 = {flags_reg[7:0], 8'h00};
  assign w23 = flags_reg[23:8];
  assign w24 = {mfault_reg, 7'h00, 1'b0, valid_reg, part_reg,
                nak_reg, busy_reg, 1'b0, cfg_err_reg, 1'b0};

  // Mastership only shows on parallel links, to the host.
  assign link_mast = master_valid_in && (master_link_in == link_sel_in)
                     && (link_sel_in == isb_pkg::ISB_LINK_BP
                      || link_sel_in == isb_pkg::ISB_LINK_RIO);
  assign w24_link  = w24 | {13'h0000, link_mast, 2'h0};

  // Result timing helpers.
  assign setup_rise   = setup_mode_in && !setup_d_reg;
  assign pulse_expire = valid_reg && (pulse_cnt_reg ==
                        {{(PULSE_W-1){1'b0}}, 1'b1});

  // Setup entry clears first; a new post restarts the pulse.
  always_comb
  begin
    valid_next = valid_reg;
    if (setup_rise)
      valid_next = 1'b0;
    else if (result_post_in)
      valid_next = 1'b1;
    else if (pulse_expire)
      valid_next = 1'b0;
  end

  // Latch results on each post.
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      flags_reg  <= 24'h000000;
      part_reg   <= 1'b0;
      mfault_reg <= 1'b0;
    end
    else if (result_post_in)
    begin
      flags_reg  <= flags_ilv;
      part_reg   <= result_part_in;
      mfault_reg <= tool_fail_in || (|gage_fault_in);
    end
  end

  // Mode, configuration and trigger flags.
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      busy_reg    <= 1'b0;
      setup_d_reg <= 1'b0;
      cfg_err_reg <= 1'b0;
      nak_reg     <= 1'b0;
    end
    else
    begin
      busy_reg    <= setup_mode_in || download_active_in;
      setup_d_reg <= setup_mode_in;
      if (cfg_block_done_in)
        cfg_err_reg <= !cfg_block_ok_in;
      if (trig_missed_in)
        nak_reg <= 1'b1;
      else if (trig_accept_in)
        nak_reg <= 1'b0;
    end
  end

  // Results valid and its pulse counter.
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      valid_reg     <= 1'b0;
      pulse_cnt_reg <= '0;
    end
    else
    begin
      valid_reg <= valid_next;
      if (result_post_in)
        pulse_cnt_reg <= pulse_len_reg;
      else if (valid_reg && pulse_cnt_reg != '0)
        pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
    end
  end

  // Link address decode, per link numbering.
  logic        lk_hit;   // Address exists on the link.
  logic [15:0] lk_data;  // Word or byte selected.
  always_comb
  begin
    lk_hit  = 1'b1;
    lk_data = 16'h0000;
    case (link_sel_in)
      isb_pkg::ISB_LINK_BP, isb_pkg::ISB_LINK_RIO:
      begin
        // Octal bit labels 10-17 land on bits 8-15.
        if (link_addr_in == ((link_sel_in == isb_pkg::ISB_LINK_BP)
            ? `ISB_BP_W22 : `ISB_RIO_W22))
          lk_data = w22;
        else if (link_addr_in == ((link_sel_in == isb_pkg::ISB_LINK_BP)
            ? `ISB_BP_W23 : `ISB_RIO_W23))
          lk_data = w23;
        else if (link_addr_in == ((link_sel_in == isb_pkg::ISB_LINK_BP)
            ? `ISB_BP_W24 : `ISB_RIO_W24))
          lk_data = w24_link;
        else
          lk_hit = 1'b0;
      end
      isb_pkg::ISB_LINK_HEX:
      begin
        case (link_addr_in)
          `ISB_HEX_22H: lk_data = {8'h00, w22[15:8]};
          `ISB_HEX_23L: lk_data = {8'h00, w23[7:0]};
          `ISB_HEX_23H: lk_data = {8'h00, w23[15:8]};
          `ISB_HEX_24L: lk_data = {8'h00, w24_link[7:0]};
          default:      lk_hit  = 1'b0;
        endcase
      end
      default:
      begin
        // Binary serial link: each word's bytes swapped.
        case (link_addr_in)
          `ISB_DF_22H: lk_data = {8'h00, w22[15:8]};
          `ISB_DF_23H: lk_data = {8'h00, w23[15:8]};
          `ISB_DF_23L: lk_data = {8'h00, w23[7:0]};
          `ISB_DF_24H: lk_data = {8'h00, w24_link[15:8]};
          `ISB_DF_24L: lk_data = {8'h00, w24_link[7:0]};
          default:     lk_hit  = 1'b0;
        endcase
      end
    endcase
  end

  // Registered link answer, one cycle after the read.
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      link_data_out  <= 16'h0000;
      link_hit_out   <= 1'b0;
      link_valid_out <= 1'b0;
    end
    else
    begin
      link_valid_out <= link_rd_in;
      if (link_rd_in)
      begin
        link_data_out <= lk_hit ? lk_data : 16'h0000;
        link_hit_out  <= lk_hit;
      end
    end
  end

  // AXI4-Lite slave state.
  logic        aw_full_reg;  // Write address held.
  logic        w_full_reg;   // Write data held.
  logic [7:0]  awaddr_reg;   // Held write address.
  logic [31:0] wdata_reg;    // Held write data.
  logic [3:0]  wstrb_reg;    // Held byte enables.
  logic        wr_go;        // Write performed now.
  logic        wr_ok;        // Write address is mapped.
  logic        ar_go;        // Read taken now.
  logic        rd_ok;        // Read address is mapped.
  logic [31:0] rd_mux;       // Read data selected.

  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign ar_go = s_axi_arvalid && s_axi_arready;
  // Status word writes are accepted and dropped.
  assign wr_ok = awaddr_reg == `ISB_A_GAGES || awaddr_reg == `ISB_A_STATUS
              || awaddr_reg == `ISB_A_CTRL || awaddr_reg == `ISB_A_IRQ_STAT
              || awaddr_reg == `ISB_A_IRQ_MASK;
  assign rd_ok = s_axi_araddr == `ISB_A_GAGES
              || s_axi_araddr == `ISB_A_STATUS
              || s_axi_araddr == `ISB_A_CTRL
              || s_axi_araddr == `ISB_A_IRQ_STAT
              || s_axi_araddr == `ISB_A_IRQ_MASK;
  assign rd_mux =
      (s_axi_araddr == `ISB_A_GAGES)    ? {w23, w22} :
      (s_axi_araddr == `ISB_A_STATUS)   ? {16'h0000, w24} :
      (s_axi_araddr == `ISB_A_CTRL)     ?
          {{(32-PULSE_W){1'b0}}, pulse_len_reg} :
      (s_axi_araddr == `ISB_A_IRQ_STAT) ? {28'h0000000, irq_stat} :
      (s_axi_araddr == `ISB_A_IRQ_MASK) ? {28'h0000000, mask_reg} :
      32'h00000000;

  // Write address and data are taken in either order.
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      aw_full_reg  <= 1'b0;
      w_full_reg   <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 32'h00000000;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ISB_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `ISB_RESP_OKAY : `ISB_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Software settings, honouring byte enables.
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      pulse_len_reg <= PULSE_W'(`ISB_PULSE_RST);
      mask_reg      <= `ISB_MASK_RST;
    end
    else if (wr_go)
    begin
      if (awaddr_reg == `ISB_A_CTRL && wstrb_reg[0])
        pulse_len_reg[7:0] <= wdata_reg[7:0];
      if (awaddr_reg == `ISB_A_CTRL && wstrb_reg[1])
        pulse_len_reg[PULSE_W-1:8] <= wdata_reg[PULSE_W-1:8];
      if (awaddr_reg == `ISB_A_IRQ_MASK && wstrb_reg[0])
        mask_reg <= wdata_reg[3:0];
    end
  end

  // Read channel, answer one cycle after the address is taken.
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `ISB_RESP_OKAY;
    end
    else if (ar_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? `ISB_RESP_OKAY : `ISB_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Interrupt events and read-to-clear.
  assign irq_set[`ISB_I_CFG_ERR]  = cfg_block_done_in && !cfg_block_ok_in;
  assign irq_set[`ISB_I_TRIG_NAK] = trig_missed_in;
  assign irq_set[`ISB_I_VALID]    = result_post_in && !setup_rise;
  assign irq_set[`ISB_I_MFAULT]   = result_post_in
                                    && (tool_fail_in || (|gage_fault_in));
  assign irq_clr = {4{ar_go && s_axi_araddr == `ISB_A_IRQ_STAT}};

  isb_flag_cell #(
    .W (4)
  ) u_irq_flags (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .set_in     (irq_set),
    .clr_in     (irq_clr),
    .q_out      (irq_stat)
  );

  assign irq_out = |(irq_stat & mask_reg);

  // Checks of the map against its causes.
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  property p_gage_latch;
    result_post_in |=> w22[9:8] == $past({gage_fault_in[0], gage_warn_in[0]})
      && w23[15:14] == $past({gage_fault_in[11], gage_warn_in[11]});
  endproperty
  a_gage_latch: assert property (p_gage_latch)
    else $error("Gage flags not latched at post.");

  property p_rio_word7;
    link_rd_in && link_sel_in == isb_pkg::ISB_LINK_RIO
      && link_addr_in == 8'h07 |=> link_data_out == $past(w23)
      && link_hit_out;
  endproperty
  a_rio_word7: assert property (p_rio_word7)
    else $error("Remote word 7 is not word 23.");

  property p_df_swap;
    link_rd_in && link_sel_in == isb_pkg::ISB_LINK_DF
      && link_addr_in == 8'h16 |=> link_data_out[7:0] == $past(w23[15:8]);
  endproperty
  a_df_swap: assert property (p_df_swap)
    else $error("Serial byte 22 is not word 23 upper byte.");

  property p_cfg_err;
    cfg_block_done_in |=> w24[1] == !$past(cfg_block_ok_in);
  endproperty
  a_cfg_err: assert property (p_cfg_err)
    else $error("Configuration error bit wrong after block.");

  property p_master;
    link_rd_in
      && ((link_sel_in == isb_pkg::ISB_LINK_BP && link_addr_in == `ISB_BP_W24)
      || (link_sel_in == isb_pkg::ISB_LINK_RIO
          && link_addr_in == `ISB_RIO_W24)) |=>
      link_data_out[2] == ($past(master_valid_in)
      && $past(master_link_in) == $past(link_sel_in));
  endproperty
  a_master: assert property (p_master)
    else $error("Mastership bit shown to wrong party.");

  property p_busy;
    ##1 w24[3] == $past(setup_mode_in || download_active_in);
  endproperty
  a_busy: assert property (p_busy)
    else $error("Busy bit does not follow setup or download.");

  property p_nak;
    trig_missed_in |=> w24[4] ##1 (w24[4] || $past(trig_accept_in));
  endproperty
  a_nak: assert property (p_nak)
    else $error("Missed trigger bit not held.");

  property p_part;
    result_post_in |=> w24[5] == $past(result_part_in);
  endproperty
  a_part: assert property (p_part)
    else $error("Part bit does not match posted part.");

  property p_valid;
    (setup_rise |=> !w24[6])
      and (result_post_in && !setup_rise |=> w24[6]);
  endproperty
  a_valid: assert property (p_valid)
    else $error("Results valid bit wrong after post or setup.");

  property p_unused;
    s_axi_rvalid && $past(ar_go) && $past(s_axi_araddr) == 8'h04
      |-> s_axi_rdata[0] == 1'b0 && s_axi_rdata[7] == 1'b0;
  endproperty
  a_unused: assert property (p_unused)
    else $error("Unused status bits read nonzero.");

  property p_mfault;
    result_post_in && tool_fail_in |=> w24[15] ##1
      (w24[15] || $past(result_post_in));
  endproperty
  a_mfault: assert property (p_mfault)
    else $error("Master fault not set on tool failure.");

endmodule

`default_nettype wire

/* File: pkg/isb_defs.svh */
// Purpose: Offsets, field positions and reset values of the status map.
// Assumes: Included by its bare name; definitions only.
// Notes: Link word, digit and byte numbers are written in hex.
// What this block does
// - Per gage warning and fault, 1 fails.
// - Remote upper byte uses octal bits 10-17.
// - Serial byte link swaps word bytes.
// - Invalid configuration block sets error bit.
// - Mastership bit 1 only to host.
// - Busy during setup or download.
// - Missed first trigger sets bit 4.
// - Bit 5 shows posted part.
// - Results valid, cleared by setup or expiry.
// - Master fault when any tool fails.
`ifndef ISB_DEFS_SVH
`define ISB_DEFS_SVH

// Backplane word numbers of the held words.
`define ISB_BP_W22 8'h16
`define ISB_BP_W23 8'h17
`define ISB_BP_W24 8'h18
// Remote link word numbers of the same words.
`define ISB_RIO_W22 8'h06
`define ISB_RIO_W23 8'h07
`define ISB_RIO_W24 8'h00
// Hex digit numbers of the byte halves on the text serial link.
`define ISB_HEX_22H 8'h0F
`define ISB_HEX_23L 8'h10
`define ISB_HEX_23H 8'h11
`define ISB_HEX_24L 8'h12
// Byte numbers on the binary serial link, bytes swapped.
`define ISB_DF_22H 8'h14
`define ISB_DF_23H 8'h16
`define ISB_DF_23L 8'h17
`define ISB_DF_24H 8'h18
`define ISB_DF_24L 8'h19
// Field positions inside status word 24.
`define ISB_B_CFG_ERR 1
`define ISB_B_MASTER 2
`define ISB_B_BUSY 3
`define ISB_B_TRIG_NAK 4
`define ISB_B_PART 5
`define ISB_B_VALID 6
`define ISB_B_MFAULT 15
// Register byte offsets on the bus.
`define ISB_A_GAGES 8'h00
`define ISB_A_STATUS 8'h04
`define ISB_A_CTRL 8'h08
`define ISB_A_IRQ_STAT 8'h0C
`define ISB_A_IRQ_MASK 8'h10
// Interrupt status bit positions.
`define ISB_I_CFG_ERR 0
`define ISB_I_TRIG_NAK 1
`define ISB_I_VALID 2
`define ISB_I_MFAULT 3
// Reset values.
`define ISB_PULSE_RST 16'h0000
`define ISB_MASK_RST 4'h0
// Bus responses.
`define ISB_RESP_OKAY 2'h0
`define ISB_RESP_SLVERR 2'h2

`endif

/* File: pkg/isb_pkg.sv */
// Purpose: Types shared by the status map files.
// Assumes: Nothing is imported; users write isb_pkg::name.
// Notes: Link selector codes match the link select port.
`default_nettype none

package isb_pkg;

  // Which host link is reading, or holds mastership.
  typedef enum logic [1:0] {
    ISB_LINK_BP  = 2'b00,
    ISB_LINK_RIO = 2'b01,
    ISB_LINK_HEX = 2'b10,
    ISB_LINK_DF  = 2'b11
  } isb_link_e;

endpackage

`default_nettype wire

/* File: tb/isb_link_host.sv */
// Purpose: Host side of the link read port; reads one map entry.
// Assumes: Same clock as the map; one read at a time.
// Notes: The answer is sampled one edge after the read is taken.
`default_nettype none
module isb_link_host (
  // Clock.
  input  wire logic              clk_sys_in,
  // Read request.
  output logic                   link_rd_out,
  output var isb_pkg::isb_link_e link_sel_out,
  output logic [7:0]             link_addr_out,
  // Answer.
  input  wire logic [15:0]       link_data_in,
  input  wire logic              link_valid_in,
  input  wire logic              link_hit_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle request lines at time zero.
  initial
  begin
    link_rd_out = 1'h0;
    link_sel_out = isb_pkg::ISB_LINK_BP;
    link_addr_out = 8'h00;
  end

  // Word number on the remote link, upper byte read as octal 10-17.
  // Byte number on the binary serial link, bytes swapped per word.
  task automatic rd(input isb_pkg::isb_link_e s, input logic [7:0] a,
                    output logic [15:0] d, output logic h, output logic v);
    @(posedge clk_sys_in);
    link_rd_out <= 1'h1;
    link_sel_out <= s;
    link_addr_out <= a;
    @(posedge clk_sys_in);
    link_rd_out <= 1'h0;
    @(posedge clk_sys_in);
    d = link_data_in;
    h = link_hit_in;
    v = link_valid_in;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_isb_top.sv */
// Purpose: Self-checking bench of the inspection status map.
// Assumes: Link reads go through the host model; AXI master below.
// Notes: Pulse length is set short so that expiry shows quickly.
`default_nettype none
module tb_isb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // One table row: link, address and expected answer.
  typedef struct packed {
    logic [1:0]  s;
    logic [7:0]  a;
    logic [15:0] e;
  } isb_row_s;
  logic clk_sys_in = 1'h0, srst_in = 1'h1;
  logic [11:0] warn = 12'h000, fault = 12'h000;
  logic tfail = 1'h0, post = 1'h0, part = 1'h0, setup = 1'h0, dl = 1'h0;
  logic cdone = 1'h0, cok = 1'h0, tmiss = 1'h0, tacc = 1'h0, mval = 1'h0;
  isb_pkg::isb_link_e mlink = isb_pkg::ISB_LINK_BP, lsel;
  logic lrd_s, lval, lhit, irq, v, h, awr, wr, bv, arr, rv;
  logic [7:0] laddr, awaddr = 8'h00, araddr = 8'h00;
  logic [15:0] ldata, d, m;
  logic [31:0] wdata = 32'h0, rdata, rd_d;
  logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
  logic [1:0] bresp, rresp, rs;
  int err_count = 0, n_tests = 0;
  isb_row_s rows[15];

  // Free-running 10 MHz clock.
  initial
  begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  isb_top #(.PULSE_W(16)) i_isb_top (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .gage_warn_in(warn), .gage_fault_in(fault), .tool_fail_in(tfail),
    .result_post_in(post), .result_part_in(part), .setup_mode_in(setup),
    .download_active_in(dl), .cfg_block_done_in(cdone),
    .cfg_block_ok_in(cok), .trig_missed_in(tmiss), .trig_accept_in(tacc),
    .master_valid_in(mval), .master_link_in(mlink), .link_rd_in(lrd_s),
    .link_sel_in(lsel), .link_addr_in(laddr), .link_data_out(ldata),
    .link_valid_out(lval), .link_hit_out(lhit), .irq_out(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr));

  isb_link_host i_isb_link_host (
    .clk_sys_in(clk_sys_in), .link_rd_out(lrd_s), .link_sel_out(lsel),
    .link_addr_out(laddr), .link_data_in(ldata), .link_valid_in(lval),
    .link_hit_in(lhit));

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One link read; the answer must come one cycle after the take.
  task automatic lrd(input logic [1:0] s, input logic [7:0] a);
    i_isb_link_host.rd(isb_pkg::isb_link_e'(s), a, d, h, v);
    chk(v, 1'h1);
  endtask

  // AXI write: address and data offered together, each released alone.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk_sys_in);
    awaddr <= a;
    wdata <= dat;
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    // Only the watchdog ends a wait for the response.
    do
    begin
      @(posedge clk_sys_in);
      if (awr) awv <= 1'h0;
      if (wr) wv <= 1'h0;
    end while (!bv);
    rs = bresp;
    br <= 1'h0;
  endtask

  // AXI read: rready held until rvalid is seen.
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk_sys_in);
    araddr <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    do
    begin
      @(posedge clk_sys_in);
      if (arr) arv <= 1'h0;
    end while (!rv);
    rd_d = rdata;
    rs = rresp;
    rr <= 1'h0;
  endtask

  // Main sequence: table of link reads, then the awkward cases.
  initial
  begin
    rows = '{{2'h0, 8'h16, 16'h5500}, {2'h0, 8'h17, 16'hAB00},
             {2'h0, 8'h18, 16'h8064}, {2'h1, 8'h06, 16'h5500},
             {2'h1, 8'h07, 16'hAB00}, {2'h1, 8'h00, 16'h8060},
             {2'h2, 8'h0F, 16'h0055}, {2'h2, 8'h10, 16'h0000},
             {2'h2, 8'h11, 16'h00AB}, {2'h2, 8'h12, 16'h0060},
             {2'h3, 8'h14, 16'h0055}, {2'h3, 8'h16, 16'h00AB},
             {2'h3, 8'h17, 16'h0000}, {2'h3, 8'h18, 16'h0080},
             {2'h3, 8'h19, 16'h0060}};
    repeat (3) @(posedge clk_sys_in);
    srst_in <= 1'h0;
    // Writes to the status word are taken and have no effect.
    axi_wr(8'h04, 32'hFFFF);
    chk(rs, 2'h0);
    axi_rd(8'h04);
    chk(rd_d, 32'h0);
    chk(irq, 1'h0);
    axi_wr(8'h10, 32'hF);
    chk(rs, 2'h0);
    // Post part 2 with gage 21-24 and 29 warnings, 29-32 faults.
    mval <= 1'h1;
    warn <= 12'h10F;
    fault <= 12'hF00;
    part <= 1'h1;
    post <= 1'h1;
    @(posedge clk_sys_in);
    post <= 1'h0;
    @(posedge clk_sys_in);
    chk(irq, 1'h1);
    foreach (rows[i])
    begin
      // Lower byte of word 22 lies outside this block's gages.
      m = (rows[i].s < 2'h2 && rows[i].a[3:0] == 4'h6) ? 16'hFF00
                                                       : 16'hFFFF;
      lrd(rows[i].s, rows[i].a);
      chk(d & m, rows[i].e);
      chk(h, 1'h1);
    end
    lrd(2'h0, 8'h30);
    chk({h, d}, 17'h0);
    // Invalid block and missed trigger, then read-clear of events.
    cdone <= 1'h1;
    tmiss <= 1'h1;
    @(posedge clk_sys_in);
    cdone <= 1'h0;
    tmiss <= 1'h0;
    lrd(2'h0, 8'h18);
    chk(d, 16'h8076);
    axi_rd(8'h0C);
    chk(rd_d, 32'hF);
    @(posedge clk_sys_in);
    chk(irq, 1'h0);
    // A valid block and an accepted trigger clear both bits.
    cdone <= 1'h1;
    cok <= 1'h1;
    tacc <= 1'h1;
    mlink <= isb_pkg::ISB_LINK_RIO;
    @(posedge clk_sys_in);
    cdone <= 1'h0;
    tacc <= 1'h0;
    lrd(2'h1, 8'h00);
    chk(d, 16'h8064);
    lrd(2'h0, 8'h18);
    chk(d, 16'h8060);
    setup <= 1'h1;
    lrd(2'h1, 8'h00);
    chk(d, 16'h802C);
    setup <= 1'h0;
    dl <= 1'h1;
    lrd(2'h1, 8'h00);
    chk(d, 16'h802C);
    dl <= 1'h0;
    lrd(2'h1, 8'h00);
    chk(d, 16'h8024);
    // Five-cycle pulse; a tool failure alone sets the master fault.
    axi_wr(8'h08, 32'h5);
    axi_rd(8'h08);
    chk(rd_d, 32'h5);
    {warn, fault, part, tfail, post} <= {24'h0, 3'h3};
    @(posedge clk_sys_in);
    post <= 1'h0;
    lrd(2'h1, 8'h00);
    chk(d, 16'h8044);
    // Fifth cycle after the post is still valid; three cycles on it is not.
    lrd(2'h1, 8'h00);
    chk(d, 16'h8044);
    lrd(2'h1, 8'h00);
    chk(d, 16'h8004);
    axi_rd(8'h20);
    chk(rs, 2'h2);
    chk(rd_d, 32'h0);
    axi_wr(8'h20, 32'h1);
    chk(rs, 2'h2);
    // A serial host never sees the mastership bit.
    mlink <= isb_pkg::ISB_LINK_DF;
    lrd(2'h3, 8'h19);
    chk(d, 16'h0000);
    // Reset in mid-run clears every flag and setting.
    srst_in <= 1'h1;
    repeat (3) @(posedge clk_sys_in);
    srst_in <= 1'h0;
    chk(irq, 1'h0);
    axi_rd(8'h08);
    chk(rd_d, 32'h0);
    lrd(2'h1, 8'h00);
    chk(d, 16'h0000);
    report_and_stop();
  end

  // Watchdog: the sequence needs under two hundred cycles.
  initial
  begin
    #200000;
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
